// File: inc/lblu_cfg.svh
// Constants for the ladder bitwise logic unit
`ifndef LBLU_CFG_SVH
`define LBLU_CFG_SVH
`define LBLU_NARROW_W 16
`define LBLU_WIDE_W 32
`define LBLU_WORD_AW 8
`define LBLU_RELAY_COUNT 256
`define LBLU_ONE_HOT_EXPANDER_OP_BIT_MAX_N 4'd8
`define LBLU_ONE_HOT_EXPANDER_OP_NUM_MAX_N 4'd4
`define LBLU_NARROW_MASK 32'h0000_ffff
`define LBLU_WIDE_MASK 32'hffff_ffff
`define LBLU_RESULT_RST 32'h0000_0000
`define LBLU_RELAY_RST 256'h0
`endif

// File: inc/lblu_pkg.sv
// Types for the ladder bitwise logic unit
package lblu_pkg;
  typedef enum logic [3:0] {
    bitwise_and_op      = 4'h0,
    bitwise_or_op       = 4'h1,
    exclusive_or_op     = 4'h2,
    twos_complement_op  = 4'h3,
    rotate_left_op      = 4'h4,
    rotate_right_op     = 4'h5,
    range_clear_op      = 4'h6,
    one_hot_expander_op = 4'h7
  } lblu_op_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_RD_HI = 3'h1,
    ST_EXEC  = 3'h2,
    ST_WR_HI = 3'h3,
    ST_CLR   = 3'h4
  } lblu_state_t;
endpackage

// File: hw/lblu_word_mem.sv
// Word register file with two registered read ports and one write port
module lblu_word_mem #(
  parameter int AW = 8,
  parameter int DW = 16
) (
  input wire logic clk,
  input wire logic [AW-1:0] rd_a_addr,
  input wire logic [AW-1:0] rd_b_addr,
  output logic [DW-1:0] rd_a_data_r,
  output logic [DW-1:0] rd_b_data_r,
  input wire logic we,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Read returns the old word on a same-cycle write
  always_ff @(posedge clk) begin
    if (we) begin
      mem[wr_addr] <= wr_data;
    end
    rd_a_data_r <= mem[rd_a_addr];
    rd_b_data_r <= mem[rd_b_addr];
  end
endmodule

// File: hw/lblu_top.sv
// Ladder bitwise logic unit: logic ops, negate, rotate, range clear, decoder
// Overview of operation
// - AND writes bitwise AND of both sources, all sixteen or thirty-two bits independently.
// - OR writes one where either source bit is one, else zero.
// - Logic operations exist in 16-bit narrow and 32-bit wide forms.
// - Exclusive OR sets bits where sources differ, narrow and wide.
// - Negation replaces operand with its two's complement.
// - Left rotate moves bits upward, top bits re-enter at bottom.
// - Right rotate moves bits downward, bottom bits re-enter at top.
// - Range clear zeroes every bit or word from first through last address.
// - Decoder width clamps to 8 for bits, 4 for words.
// - Decoder width zero writes no destination; result_r still loads 0 for bits, 1 for words.
// - Decoder activates destination whose offset equals source value.
// - Numeric decoder destination clears every bit other than the decoded one.
// - Decoded output holds after entry condition drops.
// - Instructions update destinations only with entry condition true.
// - Wide operand: named word holds low half, next word high half.
`include "lblu_cfg.svh"
module lblu_top #(
  parameter int AW = `LBLU_WORD_AW
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic entry_condition_input,
  input wire lblu_pkg::lblu_op_t req_op,
  input wire logic req_wide,
  input wire logic req_bit_dst,
  input wire logic [AW-1:0] src1_addr,
  input wire logic [AW-1:0] src2_addr,
  input wire logic [AW-1:0] dst_addr,
  input wire logic [AW-1:0] last_addr,
  input wire logic [7:0] bit_first_addr,
  input wire logic [7:0] bit_last_addr,
  input wire logic [7:0] count,
  output logic busy_r,
  output logic done_r,
  output logic [31:0] result_r,
  output logic [`LBLU_RELAY_COUNT-1:0] relay_r
);
  // ----------------------------------------------------------------
  // State and datapath signals
  // ----------------------------------------------------------------
  lblu_pkg::lblu_state_t st_r, st_nxt;
  lblu_pkg::lblu_op_t op_r, op_nxt;
  logic wide_r, wide_nxt, bit_r, bit_nxt, busy_nxt, done_nxt;
  logic [AW-1:0] src1_r, src1_nxt, src2_r, src2_nxt, dst_r, dst_nxt;
  logic [AW-1:0] last_r, last_nxt, ptr_r, ptr_nxt, a_base_r, rd_a_addr, rd_b_addr;
  logic [7:0] bfirst_r, bfirst_nxt, cnt_r, cnt_nxt, dval, bit_hit;
  logic [15:0] alo_r, alo_nxt, blo_r, blo_nxt, rd_a_data, rd_b_data;
  logic [31:0] result_nxt, op_a, op_b, res, wmask;
  logic [`LBLU_RELAY_COUNT-1:0] relay_nxt;
  logic [4:0] rot_k;
  logic [3:0] eff_n, max_n;
  logic [8:0] span;
  logic mem_we;
  logic [AW-1:0] mem_waddr;
  logic [15:0] mem_wdata;

  function automatic logic uses_dst(input lblu_pkg::lblu_op_t o);
    return o == lblu_pkg::twos_complement_op || o == lblu_pkg::rotate_left_op ||
           o == lblu_pkg::rotate_right_op;
  endfunction

  function automatic logic [31:0] rot_l(input logic [31:0] v, input logic [4:0] k, input logic w);
    logic [63:0] t64;
    logic [31:0] t32;
    t64 = {v, v} << k;
    t32 = {v[15:0], v[15:0]} << k[3:0];
    return w ? t64[63:32] : {16'h0, t32[31:16]};
  endfunction

  function automatic logic [31:0] rot_r(input logic [31:0] v, input logic [4:0] k, input logic w);
    logic [63:0] t64;
    logic [31:0] t32;
    t64 = {v, v} >> k;
    t32 = {v[15:0], v[15:0]} >> k[3:0];
    return w ? t64[31:0] : {16'h0, t32[15:0]};
  endfunction

  // ----------------------------------------------------------------
  // Word storage
  // ----------------------------------------------------------------
  // Low half read from the named word first, then the next word
  assign a_base_r = uses_dst(op_r) ? dst_r : src1_r;
  assign rd_a_addr = (st_r == lblu_pkg::ST_IDLE) ? (uses_dst(req_op) ? dst_addr : src1_addr)
                                                 : AW'(a_base_r + 1'b1);
  assign rd_b_addr = (st_r == lblu_pkg::ST_IDLE) ? src2_addr : AW'(src2_r + 1'b1);

  lblu_word_mem #(.AW(AW), .DW(`LBLU_NARROW_W)) u_mem (
    .clk(clk),
    .rd_a_addr(rd_a_addr),
    .rd_b_addr(rd_b_addr),
    .rd_a_data_r(rd_a_data),
    .rd_b_data_r(rd_b_data),
    .we(mem_we),
    .wr_addr(mem_waddr),
    .wr_data(mem_wdata)
  );

  // ----------------------------------------------------------------
  // Execute datapath
  // ----------------------------------------------------------------
  // High halves arrive straight from the memory in the execute cycle
  always_comb begin
    wmask = wide_r ? `LBLU_WIDE_MASK : `LBLU_NARROW_MASK;
    op_a = wide_r ? {rd_a_data, alo_r} : {16'h0, alo_r};
    op_b = wide_r ? {rd_b_data, blo_r} : {16'h0, blo_r};
    rot_k = wide_r ? cnt_r[4:0] : {1'b0, cnt_r[3:0]};
    max_n = bit_r ? `LBLU_ONE_HOT_EXPANDER_OP_BIT_MAX_N : `LBLU_ONE_HOT_EXPANDER_OP_NUM_MAX_N;
    eff_n = (cnt_r > {4'h0, max_n}) ? max_n : cnt_r[3:0];
    span = 9'h001 << eff_n;
    dval = op_a[7:0] & 8'(span - 9'h001);
    bit_hit = 8'(bfirst_r + dval);
    unique case (op_r)
      lblu_pkg::bitwise_and_op: res = op_a & op_b;
      lblu_pkg::bitwise_or_op: res = op_a | op_b;
      lblu_pkg::exclusive_or_op: res = op_a ^ op_b;
      lblu_pkg::twos_complement_op: res = 32'(~op_a + 32'h1) & wmask;
      lblu_pkg::rotate_left_op: res = rot_l(op_a, rot_k, wide_r);
      lblu_pkg::rotate_right_op: res = rot_r(op_a, rot_k, wide_r);
      lblu_pkg::one_hot_expander_op: res = bit_r ? {24'h0, dval} : {16'h0, 16'(16'h0001 << dval[3:0])};
      default: res = 32'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Entry condition is sampled once, when the request is taken
  always_comb begin
    logic [7:0] off;
    off = 8'h0;
    st_nxt = st_r;
    op_nxt = op_r;
    wide_nxt = wide_r;
    bit_nxt = bit_r;
    src1_nxt = src1_r;
    src2_nxt = src2_r;
    dst_nxt = dst_r;
    last_nxt = last_r;
    bfirst_nxt = bfirst_r;
    cnt_nxt = cnt_r;
    ptr_nxt = ptr_r;
    alo_nxt = alo_r;
    blo_nxt = blo_r;
    result_nxt = result_r;
    relay_nxt = relay_r;
    done_nxt = 1'b0;
    mem_we = 1'b0;
    mem_waddr = dst_r;
    mem_wdata = 16'h0;
    unique case (st_r)
      lblu_pkg::ST_IDLE: begin
        if (req_valid) begin
          op_nxt = req_op;
          wide_nxt = req_wide;
          bit_nxt = req_bit_dst;
          src1_nxt = src1_addr;
          src2_nxt = src2_addr;
          dst_nxt = dst_addr;
          last_nxt = last_addr;
          bfirst_nxt = bit_first_addr;
          cnt_nxt = count;
          if (!entry_condition_input) begin
            done_nxt = 1'b1;
          end else if (req_op == lblu_pkg::range_clear_op && req_bit_dst) begin
            // Bit range clears in one cycle; a reversed range wraps
            for (int i = 0; i < `LBLU_RELAY_COUNT; i++) begin
              off = 8'(8'(i) - bit_first_addr);
              if (off <= 8'(bit_last_addr - bit_first_addr)) begin
                relay_nxt[i] = 1'b0;
              end
            end
            done_nxt = 1'b1;
          end else if (req_op == lblu_pkg::range_clear_op) begin
            ptr_nxt = dst_addr;
            st_nxt = lblu_pkg::ST_CLR;
          end else begin
            st_nxt = lblu_pkg::ST_RD_HI;
          end
        end
      end
      lblu_pkg::ST_RD_HI: begin
        alo_nxt = rd_a_data;
        blo_nxt = rd_b_data;
        st_nxt = lblu_pkg::ST_EXEC;
      end
      lblu_pkg::ST_EXEC: begin
        result_nxt = res;
        st_nxt = lblu_pkg::ST_IDLE;
        done_nxt = 1'b1;
        if (op_r == lblu_pkg::one_hot_expander_op) begin
          if (eff_n != 4'h0 && bit_r) begin
            for (int i = 0; i < `LBLU_RELAY_COUNT; i++) begin
              off = 8'(8'(i) - bfirst_r);
              if ({1'b0, off} < span) begin
                relay_nxt[i] = (off == dval);
              end
            end
          end else if (eff_n != 4'h0) begin
            mem_we = 1'b1;
            mem_wdata = res[15:0];
          end
        end else begin
          mem_we = 1'b1;
          mem_wdata = res[15:0];
          if (wide_r) begin
            st_nxt = lblu_pkg::ST_WR_HI;
            done_nxt = 1'b0;
          end
        end
      end
      lblu_pkg::ST_WR_HI: begin
        mem_we = 1'b1;
        mem_waddr = AW'(dst_r + 1'b1);
        mem_wdata = result_r[31:16];
        done_nxt = 1'b1;
        st_nxt = lblu_pkg::ST_IDLE;
      end
      lblu_pkg::ST_CLR: begin
        mem_we = 1'b1;
        mem_waddr = ptr_r;
        mem_wdata = 16'h0;
        ptr_nxt = AW'(ptr_r + 1'b1);
        // Stop on reaching or passing the last word, so a bad range ends
        if (ptr_r >= last_r) begin
          done_nxt = 1'b1;
          st_nxt = lblu_pkg::ST_IDLE;
        end
      end
      default: st_nxt = lblu_pkg::ST_IDLE;
    endcase
    busy_nxt = st_nxt != lblu_pkg::ST_IDLE;
  end

  // Register stage of the sequencer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= lblu_pkg::ST_IDLE;
      op_r <= lblu_pkg::bitwise_and_op;
      wide_r <= 1'b0;
      bit_r <= 1'b0;
      src1_r <= '0;
      src2_r <= '0;
      dst_r <= '0;
      last_r <= '0;
      bfirst_r <= 8'h0;
      cnt_r <= 8'h0;
      ptr_r <= '0;
      alo_r <= 16'h0;
      blo_r <= 16'h0;
      result_r <= `LBLU_RESULT_RST;
      relay_r <= `LBLU_RELAY_RST;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      wide_r <= wide_nxt;
      bit_r <= bit_nxt;
      src1_r <= src1_nxt;
      src2_r <= src2_nxt;
      dst_r <= dst_nxt;
      last_r <= last_nxt;
      bfirst_r <= bfirst_nxt;
      cnt_r <= cnt_nxt;
      ptr_r <= ptr_nxt;
      alo_r <= alo_nxt;
      blo_r <= blo_nxt;
      result_r <= result_nxt;
      relay_r <= relay_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic exec;
  assign exec = st_r == lblu_pkg::ST_EXEC;

  sequence s_skip;
    st_r == lblu_pkg::ST_IDLE && req_valid && !entry_condition_input;
  endsequence
  sequence s_word_clr;
    st_r == lblu_pkg::ST_IDLE && req_valid && entry_condition_input &&
    req_op == lblu_pkg::range_clear_op && !req_bit_dst;
  endsequence

  AST_AND: assert property (exec && op_r == lblu_pkg::bitwise_and_op |=>
    result_r == ($past(op_a) & $past(op_b))) else $error("and result wrong");
  AST_OR: assert property (exec && op_r == lblu_pkg::bitwise_or_op |=>
    result_r == ($past(op_a) | $past(op_b))) else $error("or result wrong");
  AST_NARROW: assert property (exec && !wide_r |=> result_r[31:16] == 16'h0 &&
    st_r == lblu_pkg::ST_IDLE) else $error("narrow op touched high half");
  AST_XOR: assert property (exec && op_r == lblu_pkg::exclusive_or_op |=>
    result_r == ($past(op_a) ^ $past(op_b))) else $error("xor result wrong");
  AST_NEG: assert property (exec && op_r == lblu_pkg::twos_complement_op |=>
    ((result_r + $past(op_a)) & $past(wmask)) == 32'h0) else $error("negation wrong");
  AST_ROL: assert property (exec && op_r == lblu_pkg::rotate_left_op |=>
    rot_r(result_r, $past(rot_k), $past(wide_r)) == $past(op_a)) else $error("rotate left wrong");
  AST_ROR: assert property (exec && op_r == lblu_pkg::rotate_right_op |=>
    rot_l(result_r, $past(rot_k), $past(wide_r)) == $past(op_a)) else $error("rotate right wrong");
  AST_CLR_START: assert property (s_word_clr |=> st_r == lblu_pkg::ST_CLR &&
    ptr_r == $past(dst_addr)) else $error("range clear did not start");
  AST_CLR_WRITE: assert property (st_r == lblu_pkg::ST_CLR |-> mem_we &&
    mem_wdata == 16'h0 && mem_waddr == ptr_r) else $error("range clear wrote nonzero");
  AST_CLAMP: assert property (exec && op_r == lblu_pkg::one_hot_expander_op &&
    cnt_r > {4'h0, max_n} |-> eff_n == max_n) else $error("decoder width not clamped");
  AST_ONE_HOT_EXPANDER_OP_ZERO: assert property (exec && op_r == lblu_pkg::one_hot_expander_op &&
    eff_n == 4'h0 |-> !mem_we ##1 $stable(relay_r)) else $error("decoder acted on zero width");
  AST_ONE_HOT_EXPANDER_OP_WORD: assert property (exec && op_r == lblu_pkg::one_hot_expander_op && !bit_r &&
    eff_n != 4'h0 |-> mem_we && $onehot(mem_wdata) && mem_wdata[dval[3:0]]) else $error("decoder word wrong");
  AST_ONE_HOT_EXPANDER_OP_BIT: assert property (exec && op_r == lblu_pkg::one_hot_expander_op && bit_r &&
    eff_n != 4'h0 |=> relay_r[$past(bit_hit)]) else $error("decoder bit not set");
  AST_HOLD: assert property (st_r != lblu_pkg::ST_EXEC && !(st_r == lblu_pkg::ST_IDLE &&
    req_valid && entry_condition_input) |=> $stable(relay_r)) else $error("relay changed while idle");
  AST_SKIP: assert property (s_skip |-> !mem_we ##1 done_r && st_r == lblu_pkg::ST_IDLE &&
    $stable(relay_r) && $stable(result_r)) else $error("op ran without entry condition");
  AST_WIDE_HI: assert property (exec && wide_r && mem_we && op_r != lblu_pkg::one_hot_expander_op |=>
    st_r == lblu_pkg::ST_WR_HI &&
    mem_we && mem_waddr == AW'($past(dst_r) + 1'b1) && mem_wdata == result_r[31:16])
    else $error("wide high word misplaced");
  AST_ROT_MOD: assert property (exec && (op_r == lblu_pkg::rotate_left_op ||
    op_r == lblu_pkg::rotate_right_op) && rot_k == 5'h0 |=> result_r == $past(op_a))
    else $error("rotate by width changed operand");
endmodule

// File: verification/lblu_seq_model.sv
// Scan sequencer model that issues one instruction and waits for its end
module lblu_seq_model (
  input wire logic clk,
  input wire logic done_r,
  output logic req_valid,
  output logic entry_condition_input,
  output lblu_pkg::lblu_op_t req_op,
  output logic req_wide,
  output logic req_bit_dst,
  output logic [7:0] src1_addr,
  output logic [7:0] src2_addr,
  output logic [7:0] dst_addr,
  output logic [7:0] last_addr,
  output logic [7:0] bit_first_addr,
  output logic [7:0] bit_last_addr,
  output logic [7:0] count
);
  logic [55:0] fld;

  // ----------------------------------------
  // Request drive
  // ----------------------------------------
  // Operand fields travel as one bundle inside the model
  assign {src1_addr, src2_addr, dst_addr, last_addr, bit_first_addr, bit_last_addr, count} = fld;

  initial begin
    req_valid = 1'b0;
    entry_condition_input = 1'b0;
    req_op = lblu_pkg::bitwise_and_op;
    req_wide = 1'b0;
    req_bit_dst = 1'b0;
    fld = '0;
  end

  // One request per call, held for one edge; the caller keeps first below last
  task automatic issue(input lblu_pkg::lblu_op_t op, input logic en, input logic w, input logic b,
                       input logic [55:0] a, output int lat);
    @(posedge clk);
    req_valid <= 1'b1;
    entry_condition_input <= en;
    req_op <= op;
    req_wide <= w;
    req_bit_dst <= b;
    fld <= a;
    @(posedge clk);
    // Released lines flip, so a design that reads them late sees garbage
    req_valid <= 1'b0;
    entry_condition_input <= ~en;
    req_op <= lblu_pkg::lblu_op_t'(~op);
    req_wide <= ~w;
    req_bit_dst <= ~b;
    fld <= ~a;
    lat = 0;
    do begin
      @(negedge clk);
      lat++;
    end while (done_r !== 1'b1 && lat < 400);
  endtask
endmodule

// File: verification/testbench.sv
// Self-checking bench for the ladder bitwise logic unit
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid;
  logic entry_condition_input;
  lblu_pkg::lblu_op_t req_op;
  logic req_wide;
  logic req_bit_dst;
  logic [7:0] src1_addr;
  logic [7:0] src2_addr;
  logic [7:0] dst_addr;
  logic [7:0] last_addr;
  logic [7:0] bit_first_addr;
  logic [7:0] bit_last_addr;
  logic [7:0] count;
  logic busy_r;
  logic done_r;
  logic [31:0] result_r;
  logic [255:0] relay_r;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  int busy_seen = 0;

  always #2 clk = ~clk;

  lblu_top #(.AW(8)) uut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
    .entry_condition_input(entry_condition_input), .req_op(req_op), .req_wide(req_wide),
    .req_bit_dst(req_bit_dst), .src1_addr(src1_addr), .src2_addr(src2_addr), .dst_addr(dst_addr),
    .last_addr(last_addr), .bit_first_addr(bit_first_addr), .bit_last_addr(bit_last_addr),
    .count(count), .busy_r(busy_r), .done_r(done_r), .result_r(result_r), .relay_r(relay_r));

  lblu_seq_model seq (.clk(clk), .done_r(done_r), .req_valid(req_valid),
    .entry_condition_input(entry_condition_input), .req_op(req_op), .req_wide(req_wide),
    .req_bit_dst(req_bit_dst), .src1_addr(src1_addr), .src2_addr(src2_addr), .dst_addr(dst_addr),
    .last_addr(last_addr), .bit_first_addr(bit_first_addr), .bit_last_addr(bit_last_addr),
    .count(count));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [55:0] ad(int s1, int s2, int d, int l, int bf, int bl, int c);
    return {8'(s1), 8'(s2), 8'(d), 8'(l), 8'(bf), 8'(bl), 8'(c)};
  endfunction

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // Latency of zero means the note fixes none
  task automatic run(input int op, input logic en, input logic w, input logic b,
                     input logic [55:0] a, input int el);
    int lat;
    int b0;
    b0 = busy_seen;
    seq.issue(lblu_pkg::lblu_op_t'(op), en, w, b, a, lat);
    if (el > 0) chk("latency", 32'(el), 32'(lat));
    if (el > 0) chk("busy cycles", 32'(el - 1), 32'(busy_seen - b0));
  endtask

  function automatic logic [31:0] mw(int a);
    return {16'h0, uut.u_mem.mem[8'(a)]};
  endfunction

  // No port writes words, so values are built from ops: self-XOR, one-hot, rotate, OR
  task automatic setw(input int a, input logic [15:0] v);
    run(2, 1, 0, 0, ad(a, a, a, 0, 0, 0, 0), 3);
    for (int i = 0; i < 16; i++) begin
      if (v[i]) begin
        run(7, 1, 0, 0, ad(255, 0, 254, 0, 0, 0, 1), 3);
        run(4, 1, 0, 0, ad(0, 0, 254, 0, 0, 0, i), 3);
        run(1, 1, 0, 0, ad(a, 254, a, 0, 0, 0, 0), 3);
      end
    end
    chk("built word", {16'h0, v}, mw(a));
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_boot();
    chk("reset result", 32'h0, result_r);
    chk("reset relays", 32'h0, relay_r[31:0]);
    run(6, 1, 0, 0, ad(0, 0, 0, 255, 0, 0, 0), 257);
    for (int i = 0; i < 256; i++) chk("cleared word", 32'h0, mw(i));
    $display("test boot done");
  endtask

  task automatic t_logic();
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] e;
    a = 32'h8001_f831;
    b = 32'h0003_366c;
    setw(0, a[15:0]);
    setw(1, a[31:16]);
    setw(2, b[15:0]);
    setw(3, b[31:16]);
    for (int w = 0; w < 2; w++) begin
      for (int k = 0; k < 3; k++) begin
        e = k == 0 ? a & b : k == 1 ? a | b : a ^ b;
        if (w == 0) e[31:16] = 16'h0;
        run(k, 1, 1'(w), 0, ad(0, 2, 4, 0, 0, 0, 0), 3 + w);
        chk("logic result", e, result_r);
        chk("low word", {16'h0, e[15:0]}, mw(4));
        if (w == 1) chk("high word", {16'h0, e[31:16]}, mw(5));
      end
    end
    $display("test logic done");
  endtask

  task automatic t_un(input int op, input logic w, input int n, input logic [31:0] v);
    logic [63:0] y;
    logic [31:0] e;
    int k;
    k = w ? n % 32 : n % 16;
    y = w ? {v, v} : {32'h0, v[15:0], v[15:0]};
    if (op == 3) e = ~v + 32'h1;
    else if (op == 4) e = 32'((y << k) >> (w ? 32 : 16));
    else e = 32'(y >> k);
    e = e & (w ? 32'hffff_ffff : 32'h0000_ffff);
    setw(8, v[15:0]);
    if (w) setw(9, v[31:16]);
    run(op, 1, w, 0, ad(0, 0, 8, 0, 0, 0, n), 3 + w);
    chk("unary result", e, result_r);
    chk("unary word", e, (w ? mw(9) << 16 : 32'h0) | mw(8));
    $display("test unary op %0d done", op);
  endtask

  task automatic t_clear();
    logic [31:0] h4;
    logic [31:0] h8;
    logic [31:0] r;
    h4 = mw(4);
    h8 = mw(8);
    setw(5, 16'h0101);
    setw(6, 16'h8002);
    setw(7, 16'h0420);
    r = result_r;
    run(6, 1, 0, 0, ad(0, 0, 5, 7, 0, 0, 0), 4);
    for (int i = 5; i < 8; i++) chk("region word", 32'h0, mw(i));
    chk("below region", h4, mw(4));
    chk("above region", h8, mw(8));
    chk("result kept", r, result_r);
    $display("test clear done");
  endtask

  task automatic t_one_hot_expander_op();
    setw(30, 16'h0003);
    setw(32, 16'h0035);
    run(7, 1, 0, 1, ad(31, 0, 0, 0, 11, 0, 1), 3);
    run(7, 1, 0, 1, ad(30, 0, 0, 0, 16, 0, 3), 3);
    chk("relays", 32'h0008_0800, relay_r[31:0]);
    run(7, 0, 0, 1, ad(32, 0, 0, 0, 16, 0, 3), 1);
    run(7, 1, 0, 1, ad(32, 0, 0, 0, 16, 0, 0), 3);
    chk("relays held", 32'h0008_0800, relay_r[31:0]);
    setw(40, 16'h8181);
    run(7, 1, 0, 0, ad(30, 0, 40, 0, 0, 0, 0), 3);
    chk("word untouched", 32'h8181, mw(40));
    run(7, 1, 0, 0, ad(30, 0, 40, 0, 0, 0, 3), 3);
    chk("decoded word", 32'h0008, mw(40));
    run(7, 1, 0, 0, ad(32, 0, 40, 0, 0, 0, 7), 3);
    chk("clamped word", 32'h0020, mw(40));
    run(6, 1, 0, 1, ad(0, 0, 0, 0, 12, 19, 0), 1);
    chk("relays cleared", 32'h0000_0800, relay_r[31:0]);
    run(7, 1, 0, 1, ad(32, 0, 0, 0, 0, 0, 9), 3);
    chk("clamped relays low", 32'h0, relay_r[31:0]);
    chk("clamped relays high", 32'h0020_0000, relay_r[63:32]);
    chk("relay decode value", 32'h0000_0035, result_r);
    $display("test decoder done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Hang guard, well above the roughly 1400 cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (busy_r === 1'b1) busy_seen <= busy_seen + 1;
    if (cycles == 40000) begin
      mismatches++;
      end_of_test();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    t_boot();
    t_logic();
    t_un(3, 0, 0, 32'h0000_366b);
    t_un(3, 0, 0, 32'h0000_c995);
    t_un(3, 1, 0, 32'h0000_0005);
    t_un(4, 0, 4, 32'h0000_1234);
    t_un(4, 0, 20, 32'h0000_1234);
    t_un(5, 0, 11, 32'h0000_8061);
    t_un(4, 1, 32, 32'h8001_0003);
    t_un(5, 1, 8, 32'h8001_0003);
    t_clear();
    t_one_hot_expander_op();
    end_of_test();
  end
endmodule
